// >>> pkg/smdt_pkg.sv
// Constants and descriptor builders for the sector map discovery table
package smdt_pkg;

  localparam logic [7:0]  SMDT_OP_READ_ANY  = 8'h65;
  localparam logic [1:0]  SMDT_ADDR_LEN_VAR = 2'h3;
  localparam logic [1:0]  SMDT_RFU2         = 2'h3;
  localparam logic [3:0]  SMDT_LAT_VAR      = 4'hf;
  localparam logic [5:0]  SMDT_RFU6         = 6'h3f;
  localparam logic [7:0]  SMDT_RFU8         = 8'hff;
  localparam logic [3:0]  SMDT_RFU4         = 4'hf;
  localparam logic        SMDT_DESC_CMD     = 1'b0;
  localparam logic        SMDT_DESC_MAP     = 1'b1;
  localparam logic        SMDT_END          = 1'b1;
  localparam logic        SMDT_MORE         = 1'b0;
  localparam logic [7:0]  SMDT_MASK_UNIFORM = 8'h08;
  localparam logic [7:0]  SMDT_MASK_SPLIT   = 8'h40;
  localparam logic [7:0]  SMDT_MASK_TOP     = 8'h04;
  localparam logic [31:0] SMDT_ADDR_CFG3V   = 32'h0080_0004;
  localparam logic [31:0] SMDT_ADDR_CFG1V   = 32'h0080_0002;
  localparam logic [7:0]  SMDT_REGIONS_M1   = 8'h02;
  localparam logic [7:0]  SMDT_CFG_BOTTOM   = 8'h00;
  localparam logic [7:0]  SMDT_CFG_TOP      = 8'h01;
  localparam logic [23:0] SMDT_SIZE_SMALL   = 24'h0001ff;
  localparam logic [23:0] SMDT_SIZE_512M    = 24'h03fbff;
  localparam logic [23:0] SMDT_SIZE_1G      = 24'h07fbff;
  localparam logic [3:0]  SMDT_ERASE_4K     = 4'h1;
  localparam logic [3:0]  SMDT_ERASE_256K   = 4'h8;
  localparam int          SMDT_WORDS        = 14;
  localparam logic [9:0]  SMDT_TAB_BASE     = 10'h1ec;
  localparam logic [11:0] SMDT_OFS_TAB_END  = 12'h034;
  localparam logic [11:0] SMDT_OFS_CTRL     = 12'h040;
  localparam logic [11:0] SMDT_OFS_STATUS   = 12'h044;
  localparam logic [11:0] SMDT_OFS_RDCNT    = 12'h048;
  localparam int          SMDT_CTRL_DENS    = 0;
  localparam int          SMDT_CTRL_LOCK    = 1;
  localparam int          SMDT_STAT_VALID   = 3;
  localparam int          SMDT_STAT_LOCKED  = 4;
  localparam int          SMDT_STAT_DENS    = 5;

  function automatic logic [31:0] smdt_detect(input logic [7:0] mask,
                                              input logic       last);
    smdt_detect = {mask, SMDT_ADDR_LEN_VAR, SMDT_RFU2, SMDT_LAT_VAR,
                   SMDT_OP_READ_ANY, SMDT_RFU6, SMDT_DESC_CMD, last};
  endfunction : smdt_detect

  function automatic logic [31:0] smdt_header(input logic [7:0] id);
    smdt_header = {SMDT_RFU8, SMDT_REGIONS_M1, id, SMDT_RFU6,
                   SMDT_DESC_MAP, SMDT_MORE};
  endfunction : smdt_header

  function automatic logic [31:0] smdt_region(input logic [23:0] size,
                                              input logic [3:0]  erase);
    smdt_region = {size, SMDT_RFU4, erase};
  endfunction : smdt_region

endpackage : smdt_pkg

// >>> rtl/smdt_table_rom.sv
// Constant descriptor words of the sector map table
`timescale 1ns/1ps
`default_nettype none
module smdt_table_rom
  import smdt_pkg::*;
(
  input  wire logic [3:0]  word_idx,
  input  wire logic        density_1g,
  output logic      [31:0] word
);
  logic [23:0] uniform_size;

  // Only the top size byte differs between densities
  assign uniform_size = density_1g ? SMDT_SIZE_1G : SMDT_SIZE_512M;

  always_comb
  begin
    unique case (word_idx)
      4'h0: word = smdt_detect(SMDT_MASK_UNIFORM, SMDT_MORE);
      4'h1: word = SMDT_ADDR_CFG3V;
      4'h2: word = smdt_detect(SMDT_MASK_SPLIT, SMDT_MORE);
      4'h3: word = SMDT_ADDR_CFG1V;
      4'h4: word = smdt_detect(SMDT_MASK_TOP, SMDT_END);
      4'h5: word = SMDT_ADDR_CFG1V;
      4'h6: word = smdt_header(SMDT_CFG_BOTTOM);
      4'h7: word = smdt_region(SMDT_SIZE_SMALL, SMDT_ERASE_4K);
      4'h8: word = smdt_region(SMDT_SIZE_SMALL, SMDT_ERASE_256K);
      4'h9: word = smdt_region(uniform_size, SMDT_ERASE_256K);
      4'ha: word = smdt_header(SMDT_CFG_TOP);
      4'hb: word = smdt_region(uniform_size, SMDT_ERASE_256K);
      4'hc: word = smdt_region(SMDT_SIZE_SMALL, SMDT_ERASE_256K);
      4'hd: word = smdt_region(SMDT_SIZE_SMALL, SMDT_ERASE_4K);
      default: word = 32'h0000_0000;
    endcase
  end
endmodule : smdt_table_rom
`default_nettype wire

// >>> rtl/smdt_cfg_index.sv
// Map index built from the three live configuration bits
`timescale 1ns/1ps
`default_nettype none
module smdt_cfg_index
  import smdt_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       uniform_map_select,
  input  wire logic       param_sector_split,
  input  wire logic       param_sector_top_place,
  output logic      [2:0] map_index,
  output logic            map_valid
);
  typedef struct packed {
    logic [2:0] idx;
    logic       valid;
  } smdt_idx_t;

  smdt_idx_t st;
  smdt_idx_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.idx = {uniform_map_select, param_sector_split,
                   param_sector_top_place};
    // At most one bit may be set; other mixes have no map
    next_st.valid = $onehot0(next_st.idx);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign map_index = st.idx;
  assign map_valid = st.valid;
endmodule : smdt_cfg_index
`default_nettype wire

// >>> rtl/smdt_top.sv
// Sector map discovery table with APB access and a byte read port
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module smdt_top
  import smdt_pkg::*;
#(
  parameter logic DENSITY_1G_DEFAULT = 1'b0
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Live configuration bits from the volatile registers
  input  wire logic        uniform_map_select,
  input  wire logic        param_sector_split,
  input  wire logic        param_sector_top_place,
  // Byte read port toward the serial front end
  input  wire logic        tbl_rd_req,
  input  wire logic [9:0]  tbl_rd_addr,
  output logic      [7:0]  tbl_rd_byte,
  output logic             tbl_rd_valid,
  output logic             tbl_rd_hit
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [31:0] rdata;
    logic        slverr;
    logic        density_1g;
    logic        locked;
    logic [15:0] reads;
    logic [7:0]  rd_byte;
    logic        rd_valid;
    logic        rd_hit;
  } smdt_state_t;

  smdt_state_t st;
  smdt_state_t next_st;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic smdt_tab_hit(input logic [11:0] ofs);
    smdt_tab_hit = (ofs <= SMDT_OFS_TAB_END) && (ofs[1:0] == 2'h0);
  endfunction : smdt_tab_hit

  function automatic logic [15:0] smdt_bump(input logic [15:0] cnt);
    // Saturates so a long run never wraps to a small count
    if (cnt == 16'hffff)
      smdt_bump = cnt;
    else
      smdt_bump = cnt + 16'h0001;
  endfunction : smdt_bump

  // ==========================================================
  // Decode of both access paths
  // ==========================================================
  logic        apb_setup;
  logic        apb_access;
  logic        apb_tab;
  logic [3:0]  apb_idx;
  logic [31:0] apb_word;
  logic [9:0]  rd_ofs;
  logic        rd_in_tab;
  logic [3:0]  rd_idx;
  logic [1:0]  rd_lane;
  logic [31:0] rd_word;
  logic [2:0]  map_index;
  logic        map_valid;
  logic [31:0] ctrl_view;
  logic [31:0] status_view;

  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  assign apb_tab    = smdt_tab_hit(paddr);
  assign apb_idx    = paddr[5:2];

  assign rd_ofs    = tbl_rd_addr - SMDT_TAB_BASE;
  assign rd_in_tab = (tbl_rd_addr >= SMDT_TAB_BASE)
                     && (rd_ofs < 10'(SMDT_WORDS * 4));
  assign rd_idx    = rd_ofs[5:2];
  assign rd_lane   = rd_ofs[1:0];

  smdt_table_rom u_rom_apb
  (
    .word_idx   (apb_idx),
    .density_1g (st.density_1g),
    .word       (apb_word)
  );

  smdt_table_rom u_rom_byte
  (
    .word_idx   (rd_idx),
    .density_1g (st.density_1g),
    .word       (rd_word)
  );

  smdt_cfg_index u_index
  (
    .pclk                   (pclk),
    .presetn                (presetn),
    .uniform_map_select     (uniform_map_select),
    .param_sector_split     (param_sector_split),
    .param_sector_top_place (param_sector_top_place),
    .map_index              (map_index),
    .map_valid              (map_valid)
  );

  always_comb
  begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[SMDT_CTRL_DENS] = st.density_1g;
    ctrl_view[SMDT_CTRL_LOCK] = st.locked;
  end

  always_comb
  begin
    status_view = 32'h0000_0000;
    status_view[2:0] = map_index;
    status_view[SMDT_STAT_VALID] = map_valid;
    status_view[SMDT_STAT_LOCKED] = st.locked;
    status_view[SMDT_STAT_DENS] = st.density_1g;
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    next_st = st;
    next_st.rd_valid = 1'b0;

    // Read data is staged in setup so the access phase needs no wait
    if (apb_setup)
    begin
      next_st.rdata  = 32'h0000_0000;
      next_st.slverr = 1'b0;
      if (pwrite)
      begin
        // Only an unlocked control word may be written
        next_st.slverr = (paddr != SMDT_OFS_CTRL) || st.locked;
      end
      else if (apb_tab)
      begin
        next_st.rdata = apb_word;
      end
      else if (paddr == SMDT_OFS_CTRL)
      begin
        next_st.rdata = ctrl_view;
      end
      else if (paddr == SMDT_OFS_STATUS)
      begin
        next_st.rdata = status_view;
      end
      else if (paddr == SMDT_OFS_RDCNT)
      begin
        next_st.rdata = {16'h0000, st.reads};
      end
      else
      begin
        next_st.slverr = 1'b1;
      end
    end

    // Writes land only at the completing edge
    if (apb_access && pwrite && !st.slverr && pstrb[0])
    begin
      next_st.density_1g = pwdata[SMDT_CTRL_DENS];
      next_st.locked     = pwdata[SMDT_CTRL_LOCK];
    end

    // First table read locks out later writes; a control write already past its setup check still lands
    if (apb_access && !pwrite && apb_tab)
    begin
      next_st.locked = 1'b1;
      next_st.reads  = smdt_bump(st.reads);
    end

    if (tbl_rd_req)
    begin
      next_st.rd_valid = 1'b1;
      next_st.rd_hit   = rd_in_tab;
      next_st.rd_byte  = 8'h00;
      if (rd_in_tab)
      begin
        // Lane 0 is the least significant byte
        next_st.rd_byte = rd_word[8*rd_lane +: 8];
        next_st.locked  = 1'b1;
        next_st.reads   = smdt_bump(next_st.reads);
      end
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st            <= '0;
      st.density_1g <= DENSITY_1G_DEFAULT;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign pready       = 1'b1;
  assign pslverr      = apb_access && st.slverr;
  assign prdata       = st.rdata;
  assign tbl_rd_byte  = st.rd_byte;
  assign tbl_rd_valid = st.rd_valid;
  assign tbl_rd_hit   = st.rd_hit;

endmodule : smdt_top
`default_nettype wire

// >>> verif/smdt_assertions.sv
// Checker on the byte port and APB refusals
`timescale 1ns/1ps
`default_nettype none
module smdt_assertions
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pslverr,
  input wire logic        tbl_rd_req,
  input wire logic [9:0]  tbl_rd_addr,
  input wire logic [7:0]  tbl_rd_byte,
  input wire logic        tbl_rd_valid,
  input wire logic        tbl_rd_hit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] la;
  always_ff @(posedge pclk) la <= tbl_rd_addr;
  property p_byte(logic [9:0] x, logic [7:0] b);
    tbl_rd_valid && la == x |-> tbl_rd_byte == b;
  endproperty
  a_valid_pulse: assert property (tbl_rd_req |=> tbl_rd_valid)
    else $error("no valid");
  a_no_stray: assert property (tbl_rd_valid |-> $past(tbl_rd_req))
    else $error("stray valid");
  a_hit_range: assert property (tbl_rd_valid |->
    tbl_rd_hit == (la inside {[10'h1ec:10'h223]})) else $error("bad hit");
  a_miss_zero: assert property (tbl_rd_valid && !tbl_rd_hit |->
    tbl_rd_byte == 8'h00) else $error("miss byte");
  a_first_type: assert property (p_byte(10'h1ec, 8'hfc))
    else $error("type bits");
  a_end_bit: assert property (p_byte(10'h1fc, 8'hfd))
    else $error("end bit");
  a_header_more: assert property (p_byte(10'h204, 8'hfe))
    else $error("header end");
  a_ro_table: assert property (psel && penable && pwrite &&
    paddr < 12'h040 |-> pslverr) else $error("table write");
  c_end: cover property (tbl_rd_valid && la == 10'h1fc);
  c_miss: cover property (tbl_rd_valid && !tbl_rd_hit);
  c_err: cover property (pslverr);
endmodule : smdt_assertions

bind smdt_top smdt_assertions smdt_assertions_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pslverr(pslverr), .tbl_rd_req(tbl_rd_req),
  .tbl_rd_addr(tbl_rd_addr), .tbl_rd_byte(tbl_rd_byte),
  .tbl_rd_valid(tbl_rd_valid), .tbl_rd_hit(tbl_rd_hit));
`default_nettype wire

// >>> verif/smdt_host_model.sv
// Host model reading the table a byte at a time
`timescale 1ns/1ps
`default_nettype none
module smdt_host_model
(
  input  wire logic       pclk,
  input  wire logic [7:0] tbl_rd_byte,
  input  wire logic       tbl_rd_valid,
  input  wire logic       tbl_rd_hit,
  output logic            tbl_rd_req,
  output logic      [9:0] tbl_rd_addr
);
  initial tbl_rd_req = 1'b0;
  initial tbl_rd_addr = 10'h0;
  // Missing pulse leaves x, so the compare fails
  task read_word(input logic [9:0] a, output logic [31:0] w,
                 output logic h);
    h = 1'b1;
    for (int j = 0; j < 4; j++)
    begin
      @(posedge pclk);
      tbl_rd_req <= 1'b1;
      tbl_rd_addr <= a + 10'(j);
      @(posedge pclk);
      tbl_rd_req <= 1'b0;
      tbl_rd_addr <= ~tbl_rd_addr;
      @(negedge pclk);
      w[8*j +: 8] = tbl_rd_valid ? tbl_rd_byte : 8'hxx;
      h &= tbl_rd_hit;
    end
  endtask : read_word
endmodule : smdt_host_model
`default_nettype wire

// >>> verif/smdt_top_tb_top.sv
// Self-checking bench for the sector map table
`timescale 1ns/1ps
`default_nettype none
module smdt_top_tb_top;
  import smdt_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        e, h, tbl_rd_req, tbl_rd_valid, tbl_rd_hit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, x;
  logic [3:0]  pstrb;
  logic [2:0]  cfg;
  logic [9:0]  tbl_rd_addr;
  logic [7:0]  tbl_rd_byte;
  int          mismatches, checked;
  logic [31:0] ew [14] = '{32'h08ff65fc, 32'h00800004, 32'h40ff65fc,
    32'h00800002, 32'h04ff65fd, 32'h00800002, 32'hff0200fe, 32'h0001fff1,
    32'h0001fff8, 32'h03fbfff8, 32'hff0201fe, 32'h03fbfff8, 32'h0001fff8,
    32'h0001fff1};
  smdt_top smdt_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .uniform_map_select(cfg[2]), .param_sector_split(cfg[1]),
    .param_sector_top_place(cfg[0]), .tbl_rd_req(tbl_rd_req),
    .tbl_rd_addr(tbl_rd_addr), .tbl_rd_byte(tbl_rd_byte),
    .tbl_rd_valid(tbl_rd_valid), .tbl_rd_hit(tbl_rd_hit));
  smdt_host_model smdt_host_model_i (.pclk(pclk),
    .tbl_rd_byte(tbl_rd_byte), .tbl_rd_valid(tbl_rd_valid),
    .tbl_rd_hit(tbl_rd_hit), .tbl_rd_req(tbl_rd_req),
    .tbl_rd_addr(tbl_rd_addr));
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task wrap_up;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk32
  task chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chk1
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      mismatches++;
      wrap_up();
    end
  endtask : apb
  // Density set before the first read, then frozen
  task s_dens;
    apb(1'b1, SMDT_OFS_CTRL, 32'h1);
    chk1(e, 1'b0);
    for (int k = 0; k < 14; k++)
    begin
      apb(1'b0, 12'(4 * k), 32'h0);
      x = (k == 9 || k == 11) ? {8'h07, ew[k][23:0]} : ew[k];
      chk32(r, x);
    end
    apb(1'b0, SMDT_OFS_RDCNT, 32'h0);
    chk32(r, 32'h0000000e);
    apb(1'b1, SMDT_OFS_CTRL, 32'h0);
    chk1(e, 1'b1);
    apb(1'b0, SMDT_OFS_STATUS, 32'h0);
    chk32({30'h0, r[5:4]}, 32'h3);
  endtask : s_dens
  task s_index;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge pclk);
      cfg <= 3'(i);
      apb(1'b0, SMDT_OFS_STATUS, 32'h0);
      chk32({28'h0, r[3:0]}, {28'h0, i inside {0, 1, 2, 4}, 3'(i)});
    end
  endtask : s_index
  // Past the last word the port must miss
  task s_bytes;
    for (int k = 0; k <= 14; k++)
    begin
      smdt_host_model_i.read_word(10'h1ec + 10'(4 * k), r, h);
      chk32(r, k < 14 ? ew[k] : 32'h0);
      chk1(h, k < 14);
    end
  endtask : s_bytes
  task s_refuse;
    apb(1'b0, 12'h04c, 32'h0);
    chk1(e, 1'b1);
    chk32(r, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    chk1(e, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk32(r, ew[0]);
  endtask : s_refuse
  initial
  begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    cfg = 3'h0;
    mismatches = 0;
    checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    s_dens();
    s_index();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    s_bytes();
    s_refuse();
    wrap_up();
  end
endmodule : smdt_top_tb_top
`default_nettype wire
